// [hw/spirr_pkg.sv]
// Opcodes, limits, header layout, states and CRC helpers of the SPI target
// Assumes users pass the CRC polynomial in; no clock or reset here
package spirr_pkg;
   localparam logic [7:0]  OP_WRITE_REQ    = 8'h01;
   localparam logic [7:0]  OP_WRITE_FAIL   = 8'h41;
   localparam logic [7:0]  OP_READ_REQ     = 8'h02;
   localparam logic [7:0]  OP_READ_OK      = 8'h82;
   localparam logic [7:0]  OP_READ_FAIL    = 8'h42;
   localparam logic [7:0]  OP_INVALID_REQ  = 8'h04;
   localparam logic [7:0]  OP_INVALID_CRC  = 8'h08;
   localparam logic [7:0]  FILL_BYTE       = 8'hFF;
   localparam logic [7:0]  CRC_INIT        = 8'h00;
   localparam logic [7:0]  CRC_RESIDUE     = 8'h00;
   localparam logic [7:0]  CRC_POLY_DEF    = 8'h07;
   localparam logic [15:0] READ_LIMIT_DEF  = 16'h0040;
   localparam logic [15:0] BLOCK_LIMIT_DEF = 16'h1090;
   localparam int          CSUM_BIT        = 15;
   localparam logic [12:0] HDR_LEN         = 13'h0006;
   localparam logic [15:0] HB_OP           = 16'h0000;
   localparam logic [15:0] HB_ADDR_LO      = 16'h0001;
   localparam logic [15:0] HB_ADDR_HI      = 16'h0002;
   localparam logic [15:0] HB_LEN_LO       = 16'h0003;
   localparam logic [15:0] HB_LEN_HI       = 16'h0004;
   localparam logic [15:0] HB_CRC          = 16'h0005;

   typedef struct packed {
      logic [7:0]  op;
      logic [15:0] addr;
      logic [15:0] len;
   } spirr_hdr_t;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_RECV  = 6'h02,
      ST_EXEC  = 6'h04,
      ST_CHECK = 6'h08,
      ST_READY = 6'h10,
      ST_SEND  = 6'h20
   } spirr_state_t;

   function automatic logic [7:0] spirr_crc_step(input logic [7:0] crc,
                                                 input logic [7:0] data,
                                                 input logic [7:0] poly);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ({c[6:0], 1'b0} ^ poly) : {c[6:0], 1'b0};
      end
      return c;
   endfunction

   function automatic logic [7:0] spirr_hdr_byte(input spirr_hdr_t h,
                                                 input logic [7:0] crc,
                                                 input logic [2:0] idx);
      case (idx)
         3'h0:    return h.op;
         3'h1:    return h.addr[7:0];
         3'h2:    return h.addr[15:8];
         3'h3:    return h.len[7:0];
         3'h4:    return h.len[15:8];
         default: return crc;
      endcase
   endfunction

   function automatic logic [7:0] spirr_hdr_crc(input spirr_hdr_t h,
                                                input logic [7:0] poly);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = 0; i < 5; i++) begin
         c = spirr_crc_step(c, spirr_hdr_byte(h, CRC_INIT, 3'(i)), poly);
      end
      return c;
   endfunction
endpackage

// [hw/spirr_target.sv]
// SPI target transaction layer: request decode, response build, clash handling
// Assumes SPI mode 3, sclk still outside frames, memory map on clk
`timescale 1ns/1ps
module spirr_target #(
   parameter logic [15:0] READ_LIMIT  = spirr_pkg::READ_LIMIT_DEF,
   parameter logic [15:0] BLOCK_LIMIT = spirr_pkg::BLOCK_LIMIT_DEF,
   parameter logic [7:0]  CRC_POLY    = spirr_pkg::CRC_POLY_DEF
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        sclk,
   input  wire logic        ss_n,
   input  wire logic        mosi,
   output logic             miso,
   input  wire logic        host_interrupt_n_i,
   output logic             host_interrupt_n_o,
   output logic             host_interrupt_n_oe,
   input  wire logic        msg_pending,
   output logic [14:0]      mem_addr,
   output logic [15:0]      mem_len,
   output logic             mem_rd,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        mem_ok,
   input  wire logic        mem_block,
   output logic             comms_error_message
);
   import spirr_pkg::*;

   logic [2:0]   bit_cnt_q;
   logic [7:0]   rx_sh_q;
   logic [7:0]   rx_byte_q;
   logic [7:0]   tx_sh_q;
   logic         rx_tgl_q;
   logic         st_tgl_q;
   logic         miso_q;
   logic [2:0]   ss_sync_q;
   logic [2:0]   rx_sync_q;
   logic [2:0]   st_sync_q;
   spirr_state_t state_q;
   spirr_hdr_t   hdr_q;
   spirr_hdr_t   resp_q;
   logic [7:0]   hdr_crc_q;
   logic [7:0]   pay_crc_q;
   logic [15:0]  cnt_q;
   logic         clash_q;
   logic         has_data_q;
   logic         csum_q;
   logic [12:0]  ptr_q;
   logic [7:0]   dcrc_q;
   logic         fetch_q;
   logic [7:0]   tx_next_q;
   logic [14:0]  mem_addr_q;
   logic [15:0]  mem_len_q;
   logic         mem_rd_q;
   logic         int_oe_q;
   logic         cerr_q;
   logic         frame_on;
   logic         frame_was;
   logic         frame_start;
   logic         frame_end;
   logic         rx_ev;
   logic         st_ev;
   logic         rx_crc_ok;
   logic         pay_bad;
   logic [7:0]   resp_crc;
   logic [15:0]  data_cnt;
   logic [12:0]  nxt;
   logic [15:0]  didx;

   function automatic logic is_req(input logic [7:0] op);
      return (op == OP_READ_REQ) || (op == OP_WRITE_REQ);
   endfunction

   // Link side, cleared whenever select is released
   always_ff @(posedge sclk or posedge ss_n) begin
      if (ss_n) begin
         bit_cnt_q <= 3'h0;
         rx_tgl_q  <= 1'b0;
      end else begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         if (bit_cnt_q == 3'h7) begin
            rx_tgl_q <= ~rx_tgl_q;
         end
      end
   end

   always_ff @(posedge sclk) begin
      rx_sh_q <= {rx_sh_q[6:0], mosi};
      if (bit_cnt_q == 3'h7) begin
         rx_byte_q <= {rx_sh_q[6:0], mosi};
      end
   end

   // Next byte is a clk word; it changes only mid-byte, well clear of this edge
   always_ff @(negedge sclk or posedge ss_n) begin
      if (ss_n) begin
         st_tgl_q <= 1'b0;
         miso_q   <= 1'b1;
         tx_sh_q  <= 8'hFF;
      end else if (bit_cnt_q == 3'h0) begin
         st_tgl_q <= ~st_tgl_q;
         miso_q   <= tx_next_q[7];
         tx_sh_q  <= {tx_next_q[6:0], 1'b1};
      end else begin
         miso_q   <= tx_sh_q[7];
         tx_sh_q  <= {tx_sh_q[6:0], 1'b1};
      end
   end

   // Two-stage synchronisers, third stage only for change detection
   always_ff @(posedge clk) begin
      if (rst) begin
         ss_sync_q <= 3'h7;
         rx_sync_q <= 3'h0;
         st_sync_q <= 3'h0;
      end else begin
         ss_sync_q <= {ss_sync_q[1:0], ss_n};
         rx_sync_q <= {rx_sync_q[1:0], rx_tgl_q};
         st_sync_q <= {st_sync_q[1:0], st_tgl_q};
      end
   end

   assign frame_on    = ~ss_sync_q[1];
   assign frame_was   = ~ss_sync_q[2];
   assign frame_start = frame_on & ~frame_was;
   assign frame_end   = ~frame_on & frame_was;
   // Gated by both stages so the toggle clear at frame end is not an event
   assign rx_ev       = (rx_sync_q[1] ^ rx_sync_q[2]) & frame_on & frame_was;
   assign st_ev       = (st_sync_q[1] ^ st_sync_q[2]) & frame_on & frame_was;
   assign rx_crc_ok   = spirr_hdr_crc(hdr_q, CRC_POLY) == hdr_crc_q;
   assign resp_crc    = spirr_hdr_crc(resp_q, CRC_POLY);
   assign pay_bad     = hdr_q.addr[CSUM_BIT] && (pay_crc_q != CRC_RESIDUE) &&
                        ((cnt_q - {3'h0, HDR_LEN}) == hdr_q.len);
   assign data_cnt    = resp_q.len - {15'h0, csum_q};
   assign nxt         = ptr_q + 13'h1;
   assign didx        = {3'h0, nxt} - {3'h0, HDR_LEN};

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (frame_start) begin
                  state_q <= ST_RECV;
               end
            end
            ST_RECV: begin
               if (frame_end) begin
                  state_q <= (cnt_q >= {3'h0, HDR_LEN}) ? ST_EXEC : ST_IDLE;
               end
            end
            ST_EXEC: begin
               if (rx_crc_ok && !clash_q && hdr_q.op == OP_READ_REQ) begin
                  state_q <= ST_CHECK;
               end else begin
                  state_q <= ST_READY;
               end
            end
            ST_CHECK: state_q <= ST_READY;
            ST_READY: begin
               if (frame_start) begin
                  state_q <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (frame_end) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Request capture; a request that collides with a response is not stored
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q     <= 16'h0000;
         hdr_q     <= '0;
         hdr_crc_q <= CRC_INIT;
         pay_crc_q <= CRC_INIT;
      end else if (frame_start) begin
         cnt_q     <= 16'h0000;
         pay_crc_q <= CRC_INIT;
      end else if (rx_ev && (state_q == ST_RECV || state_q == ST_SEND)) begin
         cnt_q <= cnt_q + 16'h0001;
         if (state_q == ST_RECV) begin
            case (cnt_q)
               HB_OP:      hdr_q.op         <= rx_byte_q;
               HB_ADDR_LO: hdr_q.addr[7:0]  <= rx_byte_q;
               HB_ADDR_HI: hdr_q.addr[15:8] <= rx_byte_q;
               HB_LEN_LO:  hdr_q.len[7:0]   <= rx_byte_q;
               HB_LEN_HI:  hdr_q.len[15:8]  <= rx_byte_q;
               HB_CRC:     hdr_crc_q        <= rx_byte_q;
               default:    pay_crc_q <= spirr_crc_step(pay_crc_q, rx_byte_q, CRC_POLY);
            endcase
         end
      end
   end

   // Clash flag: a new set beats the clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         clash_q <= 1'b0;
      end else if ((rx_ev && state_q == ST_SEND && cnt_q == HB_OP && is_req(rx_byte_q)) ||
                   (frame_start && (state_q == ST_EXEC || state_q == ST_CHECK))) begin
         clash_q <= 1'b1;
      end else if (state_q == ST_EXEC) begin
         clash_q <= 1'b0;
      end
   end

   // Response header and outcome
   always_ff @(posedge clk) begin
      if (rst) begin
         resp_q     <= '0;
         has_data_q <= 1'b0;
         csum_q     <= 1'b0;
         cerr_q     <= 1'b0;
      end else begin
         cerr_q <= 1'b0;
         if (state_q == ST_EXEC) begin
            resp_q.addr <= hdr_q.addr;
            resp_q.len  <= hdr_q.len;
            has_data_q  <= 1'b0;
            csum_q      <= hdr_q.addr[CSUM_BIT];
            if (!rx_crc_ok) begin
               resp_q.op             <= OP_INVALID_CRC;
               resp_q.addr[CSUM_BIT] <= 1'b1;
            end else if (clash_q || !is_req(hdr_q.op)) begin
               resp_q.op <= OP_INVALID_REQ;
            end else if (hdr_q.op == OP_WRITE_REQ) begin
               resp_q.op <= OP_WRITE_FAIL;
               cerr_q    <= pay_bad;
            end else begin
               resp_q.op <= OP_READ_FAIL;
            end
         end else if (state_q == ST_CHECK) begin
            if (mem_ok && (mem_len_q <= (mem_block ? BLOCK_LIMIT : READ_LIMIT))) begin
               resp_q.op  <= OP_READ_OK;
               has_data_q <= 1'b1;
            end
         end
      end
   end

   // Transmit sequencing: next byte is staged one byte ahead of the link
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_next_q  <= FILL_BYTE;
         ptr_q      <= 13'h0000;
         dcrc_q     <= CRC_INIT;
         fetch_q    <= 1'b0;
         mem_rd_q   <= 1'b0;
         mem_addr_q <= 15'h0000;
         mem_len_q  <= 16'h0000;
      end else begin
         mem_rd_q <= 1'b0;
         fetch_q  <= 1'b0;
         case (state_q)
            ST_EXEC: begin
               mem_addr_q <= hdr_q.addr[14:0];
               mem_len_q  <= hdr_q.len;
               tx_next_q  <= FILL_BYTE;
            end
            ST_READY: begin
               tx_next_q <= resp_q.op;
               ptr_q     <= 13'h0000;
               dcrc_q    <= CRC_INIT;
            end
            ST_SEND: begin
               if (fetch_q) begin
                  tx_next_q <= mem_rdata;
                  dcrc_q    <= spirr_crc_step(dcrc_q, mem_rdata, CRC_POLY);
               end
               if (st_ev) begin
                  ptr_q <= nxt;
                  if (nxt < HDR_LEN) begin
                     tx_next_q <= spirr_hdr_byte(resp_q, resp_crc, nxt[2:0]);
                  end else if (has_data_q && didx < data_cnt) begin
                     mem_rd_q   <= 1'b1;
                     mem_addr_q <= resp_q.addr[14:0] + didx[14:0];
                     fetch_q    <= 1'b1;
                  end else if (has_data_q && csum_q && didx == data_cnt) begin
                     tx_next_q <= dcrc_q;
                  end else begin
                     tx_next_q <= FILL_BYTE;
                  end
               end
            end
            default: tx_next_q <= FILL_BYTE;
         endcase
      end
   end

   // Open-drain interrupt, quiet from one clk after the synchronised select shows a frame until the frame ends
   always_ff @(posedge clk) begin
      if (rst) begin
         int_oe_q <= 1'b0;
      end else if (frame_on) begin
         int_oe_q <= 1'b0;
      end else begin
         int_oe_q <= (state_q == ST_READY) ||
                     (state_q == ST_IDLE && msg_pending);
      end
   end

   assign miso                = miso_q;
   assign host_interrupt_n_o  = 1'b0;
   assign host_interrupt_n_oe = int_oe_q;
   assign mem_addr            = mem_addr_q;
   assign mem_len             = mem_len_q;
   assign mem_rd              = mem_rd_q;
   assign comms_error_message = cerr_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_int_quiet: assert property (frame_on |=> !int_oe_q)
      else $error("interrupt active during a frame");
   a_int_messages: assert property (state_q == ST_IDLE && msg_pending && !frame_on
      |=> int_oe_q)
      else $error("pending messages not signalled");
   a_read_cap: assert property (state_q == ST_CHECK && !mem_block && mem_len_q > READ_LIMIT
      |=> resp_q.op == OP_READ_FAIL && !has_data_q)
      else $error("oversize read not failed");
   a_block_span: assert property (state_q == ST_CHECK && mem_ok && mem_block &&
      mem_len_q <= BLOCK_LIMIT |=> resp_q.op == OP_READ_OK && has_data_q)
      else $error("block read refused");
   a_flag_strip: assert property (state_q == ST_EXEC ##1 state_q == ST_CHECK
      |-> mem_addr_q == hdr_q.addr[14:0] && csum_q == hdr_q.addr[CSUM_BIT])
      else $error("checksum flag mixed into address");
   a_ok_in_map: assert property (state_q == ST_READY && $past(state_q) == ST_CHECK &&
      resp_q.op == OP_READ_OK |-> $past(mem_ok))
      else $error("read ok outside map");
   a_crc_reject: assert property (state_q == ST_EXEC && !rx_crc_ok
      |=> resp_q.op == OP_INVALID_CRC && resp_q.addr[CSUM_BIT] ##1 state_q == ST_READY)
      else $error("bad header crc not reported");
   a_clash_reply: assert property (state_q == ST_EXEC && rx_crc_ok && clash_q
      |=> resp_q.op == OP_INVALID_REQ && !clash_q)
      else $error("clash not answered");
   a_send_hold: assert property (state_q == ST_SEND |-> hdr_q == $past(hdr_q))
      else $error("colliding request stored");
   a_echo_addr: assert property (state_q == ST_SEND && st_ev && ptr_q == 13'h0000
      |=> tx_next_q == resp_q.addr[7:0] && ptr_q == 13'h0001)
      else $error("address not echoed");
   a_filler: assert property (state_q == ST_RECV |-> tx_next_q == FILL_BYTE)
      else $error("filler not all ones");
   a_comms_err: assert property (cerr_q |-> $past(state_q) == ST_EXEC &&
      resp_q.op == OP_WRITE_FAIL)
      else $error("comms error out of place");

   c_read_ok: cover property (state_q == ST_CHECK ##1 resp_q.op == OP_READ_OK);
   c_crc_bad: cover property (state_q == ST_EXEC && !rx_crc_ok);
   c_clash: cover property ($rose(clash_q));
   c_data_sent: cover property (state_q == ST_SEND && fetch_q);
endmodule

// [verification/spirr_host.sv]
// Host-side SPI controller model, mode 3, MSB first, one frame per call
// Assumes the bench owns timing between frames and reads miso as wired
`timescale 1ns/1ps
module spirr_host (
   output logic sclk,
   output logic ss_n,
   output logic mosi,
   input  wire  miso
);
   initial begin
      sclk = 1'b1;
      ss_n = 1'b1;
      mosi = 1'b1;
   end

   // Clocks only the bytes handed in; never beyond the returned length
   task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
      logic [7:0] b;
      rx = {};
      ss_n = 1'b0;
      #(400);
      foreach (tx[i]) begin
         for (int k = 7; k >= 0; k--) begin
            sclk = 1'b0;
            mosi = tx[i][k];
            #(80);
            sclk = 1'b1;
            b[k] = miso;
            #(80);
         end
         rx.push_back(b);
      end
      #(200);
      ss_n = 1'b1;
      // Released line shows the inverse, not a held value
      mosi = ~mosi;
      #(500);
   endtask
endmodule

// [verification/tb_spi_read_response_protocol.sv]
// Self-checking bench: memory map model, scenario tasks, verdict
// Assumes spirr_pkg and spirr_target compiled first, host model in spirr_host
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_spi_read_response_protocol;
   import spirr_pkg::*;
   typedef logic [7:0] spirr_bytes_t[$];
   logic        clk;
   logic        rst;
   logic        msg_pending;
   logic        mem_rd;
   logic        mem_ok;
   logic        mem_block;
   logic        comms_error_message;
   logic        int_n_o;
   logic        host_interrupt_n_oe;
   logic [14:0] mem_addr;
   logic [15:0] mem_len;
   logic [16:0] mem_end;
   logic [7:0]  mem_rdata;
   logic [7:0]  stale_q;
   wire         sclk;
   wire         ss_n;
   wire         mosi;
   wire         miso;
   wire         host_interrupt_n;
   int          n_mismatch;
   int          comparisons;
   int          cycles;
   int          n_comms;

   spirr_target u_dut (.clk(clk), .rst(rst), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
      .miso(miso), .host_interrupt_n_i(host_interrupt_n), .host_interrupt_n_o(int_n_o),
      .host_interrupt_n_oe(host_interrupt_n_oe), .msg_pending(msg_pending),
      .mem_addr(mem_addr), .mem_len(mem_len), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
      .mem_ok(mem_ok), .mem_block(mem_block), .comms_error_message(comms_error_message));
   spirr_host u_host (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso));

   initial clk = 1'b0;
   always #50 clk = ~clk;
   // Open-drain line with pull-up
   assign host_interrupt_n = host_interrupt_n_oe ? int_n_o : 1'b1;
   // Map: 0x0000..0x03FF and 0x2000..0x3FFF; container region is 4240 bytes at 0x2000
   // Map runs past the container so the block limit, not the map, refuses oversize reads
   assign mem_end = {2'h0, mem_addr} + {1'h0, mem_len};
   assign mem_block = (mem_addr >= 15'h2000) && (mem_addr < 15'h3090);
   assign mem_ok = (mem_end <= 17'h00400) || (mem_block && mem_end <= 17'h04000);
   // Target takes read data in the cycle mem_rd stands, so the answer is combinational
   assign mem_rdata = mem_rd ? dat(mem_addr) : stale_q;

   function automatic logic [7:0] dat(input logic [14:0] a);
      return a[7:0] ^ 8'h5A;
   endfunction

   always @(posedge clk) begin
      // Stale data changes every cycle so a late sample cannot pass
      stale_q <= ~stale_q;
      if (comms_error_message === 1'b1)
         n_comms++;
      cycles++;
      if (cycles == 40000) begin
         n_mismatch++;
         results();
      end
   end

   function automatic logic [7:0] crc8(input spirr_bytes_t q);
      logic [7:0] c;
      c = CRC_INIT;
      foreach (q[i]) begin
         c = c ^ q[i];
         for (int k = 0; k < 8; k++)
            c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY_DEF) : {c[6:0], 1'b0};
      end
      return c;
   endfunction

   // Opcode, address, length, CRC over the first five
   function automatic spirr_bytes_t hdr(input logic [7:0] op, input logic [15:0] a,
                                        input logic [15:0] n);
      spirr_bytes_t q;
      q = {op, a[7:0], a[15:8], n[7:0], n[15:8]};
      q.push_back(crc8(q));
      return q;
   endfunction

   function automatic spirr_bytes_t rdok(input logic [15:0] a, input logic [15:0] n);
      spirr_bytes_t q, d;
      q = hdr(OP_READ_OK, a, n);
      for (int i = 0; i < int'(n) - int'(a[15]); i++)
         d.push_back(dat(a[14:0] + 15'(i)));
      if (a[15])
         d.push_back(crc8(d));
      foreach (d[i])
         q.push_back(d[i]);
      return q;
   endfunction

   task automatic send(input spirr_bytes_t req);
      spirr_bytes_t rx;
      u_host.frame(req, rx);
      foreach (rx[i])
         `CHK("filler", FILL_BYTE, rx[i])
   endtask

   task automatic wait_int;
      int w;
      w = 0;
      while (host_interrupt_n_oe !== 1'b1 && w < 3000) begin
         @(posedge clk);
         w++;
      end
      #1;
      `CHK("int_rise", 1'b1, host_interrupt_n_oe)
      `CHK("int_line", 1'b0, host_interrupt_n)
   endtask

   task automatic fetch(input spirr_bytes_t exp);
      spirr_bytes_t rx, tx;
      wait_int();
      foreach (exp[i])
         tx.push_back(FILL_BYTE);
      fork
         u_host.frame(tx, rx);
         begin
            repeat (6) @(posedge clk);
            #1;
            `CHK("int_drop", 1'b0, host_interrupt_n_oe)
         end
      join
      foreach (exp[i])
         `CHK("resp_byte", exp[i], rx[i])
   endtask

   task automatic t_read_ok;
      send(hdr(OP_READ_REQ, 16'h0010, 16'h0002));
      fetch(rdok(16'h0010, 16'h0002));
   endtask

   task automatic t_limits;
      send(hdr(OP_READ_REQ, 16'h0000, 16'h0040));
      fetch(rdok(16'h0000, 16'h0040));
      send(hdr(OP_READ_REQ, 16'h0000, 16'h0041));
      fetch(hdr(OP_READ_FAIL, 16'h0000, 16'h0041));
   endtask

   task automatic t_block;
      send(hdr(OP_READ_REQ, 16'h2000, 16'h0064));
      fetch(rdok(16'h2000, 16'h0064));
      send(hdr(OP_READ_REQ, 16'h2000, 16'h1091));
      fetch(hdr(OP_READ_FAIL, 16'h2000, 16'h1091));
   endtask

   task automatic t_csum;
      send(hdr(OP_READ_REQ, 16'h8010, 16'h0004));
      fetch(rdok(16'h8010, 16'h0004));
   endtask

   task automatic t_map;
      send(hdr(OP_READ_REQ, 16'h03FF, 16'h0002));
      fetch(hdr(OP_READ_FAIL, 16'h03FF, 16'h0002));
   endtask

   task automatic t_bad_crc;
      spirr_bytes_t q;
      q = hdr(OP_READ_REQ, 16'h0010, 16'h0002);
      q[5] = q[5] ^ 8'h01;
      send(q);
      fetch(hdr(OP_INVALID_CRC, 16'h8010, 16'h0002));
   endtask

   task automatic t_unknown;
      send(hdr(8'h33, 16'h0123, 16'h0005));
      fetch(hdr(OP_INVALID_REQ, 16'h0123, 16'h0005));
   endtask

   task automatic t_clash;
      spirr_bytes_t exp, rx;
      exp = rdok(16'h0010, 16'h0002);
      send(hdr(OP_READ_REQ, 16'h0010, 16'h0002));
      wait_int();
      u_host.frame(hdr(OP_READ_REQ, 16'h0020, 16'h0001), rx);
      foreach (rx[i])
         `CHK("clash_resp", exp[i], rx[i])
      send(hdr(OP_READ_REQ, 16'h0020, 16'h0001));
      fetch(hdr(OP_INVALID_REQ, 16'h0020, 16'h0001));
   endtask

   task automatic t_write_err;
      spirr_bytes_t q, p;
      p = {8'h11, 8'h22};
      q = hdr(OP_WRITE_REQ, 16'h8010, 16'h0003);
      q.push_back(p[0]);
      q.push_back(p[1]);
      q.push_back(crc8(p) ^ 8'h01);
      send(q);
      fetch(hdr(OP_WRITE_FAIL, 16'h8010, 16'h0003));
      `CHK("comms_err", 1, n_comms)
   endtask

   // Last: a pending message drives the line while idle; it is cleared again before the fetch
   task automatic t_irq;
      @(posedge clk);
      msg_pending <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      `CHK("msg_int", 1'b1, host_interrupt_n_oe)
      send(hdr(OP_READ_REQ, 16'h0030, 16'h0001));
      @(posedge clk);
      msg_pending <= 1'b0;
      fetch(rdok(16'h0030, 16'h0001));
   endtask

   task results;
      if (n_mismatch == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      msg_pending = 1'b0;
      stale_q = 8'h00;
      n_mismatch = 0;
      comparisons = 0;
      cycles = 0;
      n_comms = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      t_read_ok();
      t_limits();
      t_block();
      t_csum();
      t_map();
      t_bad_crc();
      t_unknown();
      t_clash();
      t_write_err();
      t_irq();
      results();
   end
endmodule
